//--- hw/pef_event_flags.sv
// Transceiver event flags, event mask and negotiation status registers
`include "pef_consts.svh"

module pef_event_flags
   import pef_pkg::*;
#(
   parameter int unsigned ENERGY_TIMEOUT_CYCLES = `PEF_ENERGY_CYCLES
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] management_station_address,
   input wire pef_events_t events,
   input wire logic [2:0] resolved_speed_duplex,
   output logic irq
);

   pef_mgmt_req_t req;
   logic [15:0] rd_data;
   logic [7:1] flags;
   logic [7:0] mask;
   logic [6:0] fill;
   logic [2:0] speed;
   logic neg_done_q;
   logic line_energy_present;
   logic [31:0] quiet_cnt;
   logic init_done;
   pef_events_t prev;

   // ****************************************
   // Management port
   // ****************************************
   pef_mdio_slave u_mdio (
      .clock(clock),
      .arst_n(arst_n),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe),
      .station_addr(management_station_address),
      .req(req),
      .rd_data(rd_data)
   );

   // ****************************************
   // Energy indication
   // ****************************************
   // Counts quiet cycles; any energy restarts the wait
   wire quiet_expired = (quiet_cnt == ENERGY_TIMEOUT_CYCLES - 1);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         line_energy_present <= 1'b1;
         quiet_cnt <= 32'h0;
      end else if (events.energy_seen) begin
         line_energy_present <= 1'b1;
         quiet_cnt <= 32'h0;
      end else if (line_energy_present) begin
         quiet_cnt <= quiet_cnt + 32'h1;
         if (quiet_expired) begin
            line_energy_present <= 1'b0; // RULE_15
         end
      end
   end

   // ****************************************
   // Event detection
   // ****************************************
   // Edges, so a condition that stays true raises its flag only once
   wire next_energy = events.energy_seen | (line_energy_present & ~quiet_expired);
   wire [7:1] hit;
   assign hit[`PEF_BIT_ENERGY] = next_energy != line_energy_present; // RULE_01 RULE_15
   assign hit[`PEF_BIT_NEG_DONE] = events.neg_done & ~prev.neg_done; // RULE_02
   assign hit[`PEF_BIT_REMOTE_FAULT] = events.remote_fault & ~prev.remote_fault; // RULE_03
   assign hit[`PEF_BIT_LINK_LOST] = ~events.link_up & prev.link_up; // RULE_04
   assign hit[`PEF_BIT_PARTNER_ACK] = events.partner_ack & ~prev.partner_ack; // RULE_05
   assign hit[`PEF_BIT_PAR_FAULT] = events.parallel_fault & ~prev.parallel_fault; // RULE_06
   assign hit[`PEF_BIT_PAGE_RX] = events.page_rx & ~prev.page_rx; // RULE_07

   wire rd_flags = req.rd && (req.regad == `PEF_REG_FLAGS);
   wire wr_mask = req.wr && (req.regad == `PEF_REG_MASK);
   wire wr_status = req.wr && (req.regad == `PEF_REG_STATUS);

   // ****************************************
   // Latched flags, clear on read
   // ****************************************
   // A new event in the read cycle wins over the clear and stays set
   wire [7:1] next_flags = (rd_flags ? 7'h0 : flags) | hit; // RULE_17
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flags <= 7'h0;
         init_done <= 1'b0;
         prev <= '0;
      end else begin
         prev <= events;
         init_done <= 1'b1;
         flags <= next_flags;
         if (!init_done) begin
            flags[`PEF_BIT_LINK_LOST] <= ~events.link_up; // RULE_09
            prev.link_up <= events.link_up;
         end
      end
   end

   // ****************************************
   // Mask and status registers
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mask <= `PEF_MASK_RST;
         fill <= `PEF_FILL_RST;
         speed <= `PEF_SPEED_RST;
         neg_done_q <= 1'b0;
      end else begin
         neg_done_q <= events.neg_done; // RULE_11
         speed <= resolved_speed_duplex; // RULE_13
         if (wr_mask) begin
            mask <= req.wdata[7:0]; // RULE_10
         end
         if (wr_status) begin
            fill <= req.wdata[`PEF_ST_FILL_HI:`PEF_ST_FILL_LO]; // RULE_12
         end
      end
   end

   // ****************************************
   // Read data and interrupt
   // ****************************************
   // Unused bits and unmapped offsets read as zero
   wire [15:0] flags_word = {8'h0, flags, 1'b0}; // RULE_08
   wire [15:0] mask_word = {8'h0, mask};
   wire [15:0] status_word = {3'h0, neg_done_q, fill, speed, 2'h0}; // RULE_14
   assign rd_data = (req.regad == `PEF_REG_FLAGS) ? flags_word :
                    (req.regad == `PEF_REG_MASK) ? mask_word :
                    (req.regad == `PEF_REG_STATUS) ? status_word : 16'h0;
   assign irq = |({flags, 1'b0} & mask); // RULE_18

   // ****************************************
   // Assertions
   // ****************************************
   property p_energy_flag;
      @(posedge clock) disable iff (!arst_n)
      (line_energy_present != $past(line_energy_present)) |-> flags[`PEF_BIT_ENERGY];
   endproperty
   a_energy_flag: assert property (p_energy_flag) else $error("energy change did not set flag"); // RULE_01

   property p_neg_done;
      @(posedge clock) disable iff (!arst_n)
      $rose(events.neg_done) |=> flags[`PEF_BIT_NEG_DONE] && neg_done_q;
   endproperty
   a_neg_done: assert property (p_neg_done) else $error("negotiation done not latched"); // RULE_02

   property p_remote_fault;
      @(posedge clock) disable iff (!arst_n)
      init_done && $rose(events.remote_fault) |=> flags[`PEF_BIT_REMOTE_FAULT];
   endproperty
   a_remote_fault: assert property (p_remote_fault) else $error("remote fault not latched"); // RULE_03

   // Set wins over a read in the same cycle, so no read exemption is needed
   property p_partner_ack;
      @(posedge clock) disable iff (!arst_n)
      init_done && $rose(events.partner_ack) |=> flags[`PEF_BIT_PARTNER_ACK];
   endproperty
   a_partner_ack: assert property (p_partner_ack) else $error("partner acknowledge not latched"); // RULE_05

   property p_par_fault;
      @(posedge clock) disable iff (!arst_n)
      init_done && $rose(events.parallel_fault) |=> flags[`PEF_BIT_PAR_FAULT];
   endproperty
   a_par_fault: assert property (p_par_fault) else $error("parallel detect fault not latched"); // RULE_06

   property p_page_rx;
      @(posedge clock) disable iff (!arst_n)
      init_done && $rose(events.page_rx) |=> flags[`PEF_BIT_PAGE_RX];
   endproperty
   a_page_rx: assert property (p_page_rx) else $error("page received not latched"); // RULE_07

   property p_link_lost;
      @(posedge clock) disable iff (!arst_n)
      init_done && $fell(events.link_up) |=> flags[`PEF_BIT_LINK_LOST];
   endproperty
   a_link_lost: assert property (p_link_lost) else $error("link drop not latched"); // RULE_04

   property p_link_init;
      @(posedge clock) disable iff (!arst_n)
      !init_done |=> flags[`PEF_BIT_LINK_LOST] == !$past(events.link_up);
   endproperty
   a_link_init: assert property (p_link_init) else $error("link lost flag not taken from line"); // RULE_09

   property p_clear_on_read;
      @(posedge clock) disable iff (!arst_n)
      init_done && rd_flags && (hit == 7'h0) |=> flags == 7'h0 ##1 (flags == 7'h0 || $past(hit) != 7'h0);
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("flags not cleared by read"); // RULE_17

   property p_flag_zero_bits;
      @(posedge clock) disable iff (!arst_n)
      rd_flags |-> rd_data[15:8] == 8'h0 && !rd_data[0];
   endproperty
   a_flag_zero_bits: assert property (p_flag_zero_bits) else $error("unused flag bits not zero"); // RULE_08

   property p_status_zero_bits;
      @(posedge clock) disable iff (!arst_n)
      req.rd && req.regad == `PEF_REG_STATUS |-> rd_data[15:13] == 3'h0 && rd_data[1:0] == 2'h0
         && rd_data[`PEF_ST_SPEED_HI:`PEF_ST_SPEED_LO] == speed;
   endproperty
   a_status_zero_bits: assert property (p_status_zero_bits) else $error("status read wrong"); // RULE_14

   property p_mask_write;
      @(posedge clock) disable iff (!arst_n)
      wr_mask |=> mask == $past(req.wdata[7:0]) ##1 irq == |({flags, 1'b0} & mask);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write not taken"); // RULE_10

   property p_irq;
      @(posedge clock) disable iff (!arst_n)
      flags[`PEF_BIT_PAGE_RX] && mask[`PEF_BIT_PAGE_RX] |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE_18

   property p_energy_timeout;
      @(posedge clock) disable iff (!arst_n)
      quiet_expired && line_energy_present && !events.energy_seen |=> !line_energy_present && quiet_cnt != 32'h0;
   endproperty
   a_energy_timeout: assert property (p_energy_timeout) else $error("energy did not time out"); // RULE_15

   c_read_flags: cover property (@(posedge clock) disable iff (!arst_n) rd_flags && flags != 7'h0);
   c_mask_write: cover property (@(posedge clock) disable iff (!arst_n) wr_mask);
   c_irq_rise: cover property (@(posedge clock) disable iff (!arst_n) $rose(irq));
   c_energy_off: cover property (@(posedge clock) disable iff (!arst_n) $fell(line_energy_present));
   c_link_drop: cover property (@(posedge clock) disable iff (!arst_n) init_done && $fell(events.link_up));

endmodule // pef_event_flags

//--- pkg/pef_consts.svh
// Constants for the transceiver event flag and link status block
// Notes on behaviour
// RULE_01 - Energy flag (bit 7) sets when the energy indication changes; held until read.
// RULE_02 - Negotiation done flag (bit 6) latches when auto-negotiation completes.
// RULE_03 - Remote fault flag (bit 5) latches when partner reports a fault.
// RULE_04 - Link lost flag (bit 4) latches when link status drops.
// RULE_05 - Partner acknowledge flag (bit 3) latches on partner acknowledge.
// RULE_06 - Parallel detect fault flag (bit 2) latches on parallel-detection fault.
// RULE_07 - Page received flag (bit 1) latches when a negotiation page arrives.
// RULE_08 - Flag bits 15..8 and 0 read zero; reader ignores them.
// RULE_09 - Link lost flag after reset reflects current line link state.
// RULE_10 - Mask bits 7..0 writable, reset zero; one enables the source.
// RULE_11 - Status bit 12 is one only when auto-negotiation finished; resets zero.
// RULE_12 - Status bits 11..5 reset to 0000010b; writers write that pattern.
// RULE_13 - Status bits 4..2 show resolved speed and duplex code.
// RULE_14 - Status bits 15..13 and 1..0 are read-only zeros.
// RULE_15 - Energy indication falls after 256 ms without energy; change raises flag.
// RULE_16 - Registers reached over management serial port at programmable station address.
// RULE_17 - Flags clear on read unless the event recurs in that cycle.
// RULE_18 - Interrupt output high while any flag is set with its mask bit.
`ifndef PEF_CONSTS_SVH
`define PEF_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PEF_REG_FLAGS 5'h1d
`define PEF_REG_MASK 5'h1e
`define PEF_REG_STATUS 5'h1f

// ****************************************
// Field positions and reset values
// ****************************************
`define PEF_BIT_ENERGY 7
`define PEF_BIT_NEG_DONE 6
`define PEF_BIT_REMOTE_FAULT 5
`define PEF_BIT_LINK_LOST 4
`define PEF_BIT_PARTNER_ACK 3
`define PEF_BIT_PAR_FAULT 2
`define PEF_BIT_PAGE_RX 1
`define PEF_ST_DONE_BIT 12
`define PEF_ST_FILL_HI 11
`define PEF_ST_FILL_LO 5
`define PEF_ST_SPEED_HI 4
`define PEF_ST_SPEED_LO 2
`define PEF_MASK_RST 8'h00
`define PEF_FILL_RST 7'h02
`define PEF_SPEED_RST 3'h0

// ****************************************
// Management frame fields
// ****************************************
`define PEF_OP_READ 2'h2
`define PEF_OP_WRITE 2'h1
`define PEF_HDR_LAST 5'h0b
`define PEF_BODY_LAST 5'h11
`define PEF_DATA_LAST 5'h0f

// ****************************************
// Timing
// ****************************************
`define PEF_ENERGY_TIMEOUT_MS 256
`define PEF_CLK_MHZ 250
`define PEF_ENERGY_CYCLES (`PEF_ENERGY_TIMEOUT_MS * 1000 * `PEF_CLK_MHZ)

`endif

//--- pkg/pef_pkg.sv
// Types shared by the event flag block and its management port
package pef_pkg;

   // Management port frame states
   typedef enum logic [2:0] {
      pef_st_idle,
      pef_st_start,
      pef_st_hdr,
      pef_st_body
   } pef_mdio_state_t;

   // One register access from the management port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] regad;
      logic [15:0] wdata;
   } pef_mgmt_req_t;

   // Line and negotiation conditions from the transceiver core
   typedef struct packed {
      logic energy_seen;
      logic link_up;
      logic neg_done;
      logic remote_fault;
      logic partner_ack;
      logic parallel_fault;
      logic page_rx;
   } pef_events_t;

endpackage

//--- hw/pef_mdio_slave.sv
// Serial management port slave: frame decode, read shift-out, write capture
`include "pef_consts.svh"

module pef_mdio_slave
   import pef_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] station_addr,
   output pef_mgmt_req_t req,
   input wire logic [15:0] rd_data
);

   // Glitch filter: accept a level once second and third stages agree
   function automatic logic filt(input logic s2, input logic s3, input logic lvl);
      filt = (s2 == s3) ? s3 : lvl;
   endfunction

   logic [2:0] mdc_sync;
   logic [2:0] mdio_sync;
   logic mdc_lvl;
   logic mdio_lvl;
   pef_mdio_state_t state;
   logic [4:0] cnt;
   logic [11:0] hdr;
   logic [15:0] shift;
   logic prev_one;
   logic mine;
   logic is_read;

   wire next_mdc_lvl = filt(mdc_sync[1], mdc_sync[2], mdc_lvl);
   wire next_mdio_lvl = filt(mdio_sync[1], mdio_sync[2], mdio_lvl);
   wire mdc_rise = next_mdc_lvl & ~mdc_lvl;
   wire [11:0] next_hdr = {hdr[10:0], next_mdio_lvl};
   wire hdr_mine = (next_hdr[9:5] == station_addr); // RULE_16
   wire hdr_read = (next_hdr[11:10] == `PEF_OP_READ);
   wire hdr_write = (next_hdr[11:10] == `PEF_OP_WRITE);

   // ****************************************
   // Input synchronisers
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mdc_sync <= 3'h0;
         mdio_sync <= 3'h7;
         mdc_lvl <= 1'b0;
         mdio_lvl <= 1'b1;
      end else begin
         mdc_sync <= {mdc_sync[1:0], mdc};
         mdio_sync <= {mdio_sync[1:0], mdio_in};
         mdc_lvl <= next_mdc_lvl;
         mdio_lvl <= next_mdio_lvl;
      end
   end

   // ****************************************
   // Frame engine, one step per rising clock of the management line
   // ****************************************
   // Frames for other stations are still counted out so their data bits
   // never look like a fresh start pattern.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= pef_st_idle;
         cnt <= 5'h0;
         hdr <= 12'h0;
         shift <= 16'h0;
         prev_one <= 1'b0;
         mine <= 1'b0;
         is_read <= 1'b0;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
         req <= '0;
      end else begin
         req.rd <= 1'b0;
         req.wr <= 1'b0;
         if (req.rd) begin
            shift <= rd_data; // Captured the cycle the read strobe stands
         end
         if (mdc_rise) begin
            case (state)
               pef_st_idle: begin
                  prev_one <= next_mdio_lvl;
                  if (prev_one && !next_mdio_lvl) begin
                     state <= pef_st_start;
                  end
               end
               pef_st_start: begin
                  cnt <= `PEF_HDR_LAST;
                  prev_one <= 1'b0;
                  state <= next_mdio_lvl ? pef_st_hdr : pef_st_idle;
               end
               pef_st_hdr: begin
                  hdr <= next_hdr;
                  cnt <= cnt - 5'h1;
                  if (cnt == 5'h0) begin
                     state <= pef_st_body;
                     cnt <= `PEF_BODY_LAST;
                     mine <= hdr_mine & (hdr_read | hdr_write);
                     is_read <= hdr_read;
                     req.regad <= next_hdr[4:0];
                     req.rd <= hdr_mine & hdr_read;
                  end
               end
               pef_st_body: begin
                  cnt <= cnt - 5'h1;
                  if (mine && is_read) begin
                     mdio_oe <= (cnt != 5'h0);
                     mdio_out <= (cnt == `PEF_BODY_LAST) ? 1'b0 : shift[15];
                     if (cnt != `PEF_BODY_LAST) begin
                        shift <= {shift[14:0], 1'b0};
                     end
                  end else if (cnt <= `PEF_DATA_LAST) begin
                     shift <= {shift[14:0], next_mdio_lvl};
                  end
                  if (cnt == 5'h0) begin
                     state <= pef_st_idle;
                     req.wr <= mine & ~is_read;
                     req.wdata <= {shift[14:0], next_mdio_lvl};
                  end
               end
               default: state <= pef_st_idle;
            endcase
         end
      end
   end

endmodule // pef_mdio_slave

//--- bench/pef_station_model.sv
// Management station model that clocks whole frames onto the serial management pins
module pef_station_model (
   input wire logic clock,
   input wire logic mdio_line,
   output logic mdc,
   output logic host_oe,
   output logic host_bit
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock stands still low between frames
   initial begin
      mdc = 1'b0;
      host_oe = 1'b0;
      host_bit = 1'b0;
   end

   // ****************************************
   // Frame engine
   // ****************************************
   // Two preamble ones, start, op, station, register, turnaround, data; msb first.
   // The low mdc phase lasts five clocks and the high one six, above the four the port needs to resync.
   task automatic frame(input logic [1:0] op, input logic [4:0] sta, input logic [4:0] regad,
         input logic [15:0] wdata, output logic [31:0] seen);
      logic [33:0] bits;
      bits = {2'b11, 2'b01, op, sta, regad, 2'b10, wdata};
      seen = '0;
      for (int i = 33; i >= 0; i--) begin
         @(negedge clock);
         mdc <= 1'b0;
         host_oe <= (op == 2'h1) || (i > 17); // Read hands the line over at turnaround
         host_bit <= bits[i];
         repeat (5) @(negedge clock);
         if (i < 32) begin
            seen[i] = mdio_line; // Value present at the rising edge
         end
         mdc <= 1'b1;
         repeat (5) @(negedge clock);
      end
      @(negedge clock);
      mdc <= 1'b0;
      host_oe <= 1'b0;
   endtask
endmodule // pef_station_model

//--- bench/tb_top.sv
// Self-checking bench for the event flag, mask and status registers
`include "pef_consts.svh"

module tb_top
   import pef_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      pef_events_t ev;
      logic [2:0] spd;
      logic [15:0] flags;
   } pef_row_t;

   localparam pef_events_t base_ev = 7'h60;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic mdc;
   logic host_oe;
   logic host_bit;
   logic mdio_out;
   logic mdio_oe;
   logic irq;
   logic [4:0] sta_addr = 5'h01;
   pef_events_t events = 7'h40;
   logic [2:0] speed = 3'h1;
   logic [31:0] seen;
   int err_total = 0;
   int checked = 0;
   // Line has a pull-up, so a released line reads one
   wire logic mdio_line = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);

   // One pulse per row, then back to the quiet base pattern
   pef_row_t rows [7] = '{
      '{7'h70, 3'h1, 16'h0040},
      '{7'h68, 3'h5, 16'h0020},
      '{7'h64, 3'h2, 16'h0008},
      '{7'h62, 3'h6, 16'h0004},
      '{7'h61, 3'h1, 16'h0002},
      '{7'h40, 3'h5, 16'h0010},
      '{7'h5f, 3'h2, 16'h007e}
   };

   always #2 clock = ~clock;

   pef_event_flags #(.ENERGY_TIMEOUT_CYCLES(50)) u_pef_event_flags (
      .clock(clock), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .management_station_address(sta_addr), .events(events),
      .resolved_speed_duplex(speed), .irq(irq));

   pef_station_model station (.clock(clock), .mdio_line(mdio_line), .mdc(mdc), .host_oe(host_oe),
      .host_bit(host_bit));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [4:0] sta, input logic [4:0] regad, input logic [15:0] exp);
      station.frame(`PEF_OP_READ, sta, regad, 16'h0000, seen);
      check(seen[15:0], exp);
   endtask

   task automatic wr(input logic [4:0] regad, input logic [15:0] data);
      station.frame(`PEF_OP_WRITE, 5'h01, regad, data, seen);
   endtask

   task automatic finish_test;
      if (err_total == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Sequence needs about 14000 clocks; the limit leaves ample slack
   initial begin
      #200000;
      err_total++;
      finish_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      arst_n <= 1'b1;
      repeat (8) @(negedge clock);
      rd(5'h01, `PEF_REG_FLAGS, 16'h0010);
      events <= base_ev;
      rd(5'h01, `PEF_REG_FLAGS, 16'h0000);
      rd(5'h01, `PEF_REG_MASK, 16'h0000);
      rd(5'h01, `PEF_REG_STATUS, 16'h0044);
      wr(`PEF_REG_MASK, 16'hffff);
      rd(5'h01, `PEF_REG_MASK, 16'h00ff);
      // Table rows: flag set, interrupt raised, cleared by read, speed code shown
      foreach (rows[i]) begin
         events <= rows[i].ev;
         speed <= rows[i].spd;
         repeat (3) @(negedge clock);
         events <= base_ev;
         repeat (2) @(negedge clock);
         check({15'h0, irq}, 16'h0001);
         rd(5'h01, `PEF_REG_FLAGS, rows[i].flags);
         check({15'h0, irq}, 16'h0000);
         rd(5'h01, `PEF_REG_STATUS, {4'h0, 7'h02, rows[i].spd, 2'h0});
      end
      // Done bit follows negotiation level
      events <= 7'h70;
      repeat (3) @(negedge clock);
      rd(5'h01, `PEF_REG_STATUS, 16'h1048);
      events <= base_ev;
      rd(5'h01, `PEF_REG_FLAGS, 16'h0040);
      rd(5'h01, `PEF_REG_STATUS, 16'h0048);
      // Masked source keeps the interrupt low until its bit is enabled
      wr(`PEF_REG_MASK, 16'h0080);
      events <= 7'h61;
      repeat (3) @(negedge clock);
      events <= base_ev;
      check({15'h0, irq}, 16'h0000);
      wr(`PEF_REG_MASK, 16'h0002);
      check({15'h0, irq}, 16'h0001);
      // Refused accesses must leave the pending flag alone
      rd(5'h02, `PEF_REG_FLAGS, 16'hffff);
      // Undefined op code: port stays silent, line reads the pull-up
      station.frame(2'h3, 5'h01, `PEF_REG_FLAGS, 16'h0000, seen);
      check(seen[15:0], 16'hffff);
      rd(5'h01, 5'h10, 16'h0000);
      wr(`PEF_REG_FLAGS, 16'hffff);
      rd(5'h01, `PEF_REG_FLAGS, 16'h0002);
      wr(`PEF_REG_STATUS, 16'h0040);
      rd(5'h01, `PEF_REG_STATUS, 16'h0048);
      // Short energy gap is ignored; a long one and the return both raise the flag
      events <= 7'h20;
      repeat (40) @(negedge clock);
      events <= base_ev;
      rd(5'h01, `PEF_REG_FLAGS, 16'h0000);
      events <= 7'h20;
      repeat (60) @(negedge clock);
      rd(5'h01, `PEF_REG_FLAGS, 16'h0080);
      events <= base_ev;
      repeat (3) @(negedge clock);
      rd(5'h01, `PEF_REG_FLAGS, 16'h0080);
      // Mid-run reset with the link up: link lost flag starts clear, mask back to zero
      arst_n <= 1'b0;
      repeat (2) @(negedge clock);
      arst_n <= 1'b1;
      repeat (8) @(negedge clock);
      rd(5'h01, `PEF_REG_FLAGS, 16'h0000);
      rd(5'h01, `PEF_REG_MASK, 16'h0000);
      finish_test();
   end
endmodule // tb_top
